/* File: shared/ictd_map.svh */
// Purpose: constants for the input capture timer with deglitch
// Assumes: peripheral clock at 50 MHz
// Notes: widths, reset values and field codes
`ifndef ICTD_MAP_SVH
`define ICTD_MAP_SVH
`define ICTD_CHANNELS      6
`define ICTD_CNT_W         32
`define ICTD_NC_W          8
`define ICTD_PRE_W         8
`define ICTD_CNT_RST       32'h0000_0000
`define ICTD_CNT_MAX       32'hffff_ffff
`define ICTD_NC_RST        8'h00
`define ICTD_EDGE_OFF      2'h0
`define ICTD_EDGE_RISE     2'h1
`define ICTD_EDGE_FALL     2'h2
`define ICTD_EDGE_BOTH     2'h3
`define ICTD_WRITE_CYCLES  2
`endif

/* File: shared/ictd_pkg.sv */
// Purpose: types for the input capture timer with deglitch
// Assumes: constants come from ictd_map.svh
// Notes: one filter mode enum and one filter state enum
package ictd_pkg;
   typedef enum logic {ICTD_MODE_PREMATURE, ICTD_MODE_MIN_LEVEL} ictd_mode_t;
   typedef enum logic [1:0] {ICTD_NC_IDLE, ICTD_NC_MASK, ICTD_NC_WAIT} ictd_nc_state_t;
endpackage

/* File: rtl/ictd_deglitch.sv */
// Purpose: one channel noise canceler with two filter modes
// Assumes: input already synchronised to i_clk
// Notes: counts on a shared count enable, independent of the timer enable
`timescale 1ns/1ps
`include "ictd_map.svh"
module ictd_deglitch
   import ictd_pkg::*;
#(
   parameter int NC_W = `ICTD_NC_W
) (
   input  wire logic            i_clk,
   input  wire logic            i_rstn,
   input  wire logic            i_in,
   input  wire logic            i_enable,
   input  wire logic            i_mode,
   input  wire logic            i_tick,
   input  wire logic [NC_W-1:0] i_limit,
   output logic                 o_out,
   output logic [NC_W-1:0]      o_count
);
   initial begin
      if (NC_W < 1) $error("ictd_deglitch: NC_W must be at least 1");
   end

   ictd_nc_state_t  state;
   ictd_nc_state_t  next_state;
   logic [NC_W-1:0] count;
   logic [NC_W-1:0] next_count;
   logic            filt;
   logic            next_filt;
   logic            prev_in;
   logic            match;
   logic            change;

   assign match   = (count == i_limit);
   assign change  = (i_in != prev_in);
   assign o_out   = filt;
   assign o_count = count;

   always_comb begin
      next_state = state;
      next_count = count;
      next_filt  = filt;
      unique case (state)
         ICTD_NC_IDLE: begin
            if (!i_enable) begin
               next_filt = i_in;
            end else if (i_in != filt) begin
               next_count = '0;
               if (i_mode == ICTD_MODE_PREMATURE) begin
                  next_filt  = i_in;
                  next_state = ICTD_NC_MASK;
               end else begin
                  next_state = ICTD_NC_WAIT;
               end
            end
         end
         ICTD_NC_MASK: begin
            // input ignored here even if enable drops
            if (match) begin
               next_filt  = i_in;
               next_count = `ICTD_NC_RST;
               next_state = ICTD_NC_IDLE;
            end else if (i_tick) begin
               next_count = count + 1'b1;
            end
         end
         ICTD_NC_WAIT: begin
            if (change) begin
               next_count = `ICTD_NC_RST;
               next_state = ICTD_NC_IDLE;
            end else if (match) begin
               next_filt  = i_in;
               next_count = `ICTD_NC_RST;
               next_state = ICTD_NC_IDLE;
            end else if (i_tick) begin
               next_count = count + 1'b1;
            end
         end
         default: begin
            next_state = ICTD_NC_IDLE;
            next_count = `ICTD_NC_RST;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state   <= ICTD_NC_IDLE;
         count   <= `ICTD_NC_RST;
         filt    <= 1'b0;
         prev_in <= 1'b0;
      end else begin
         state   <= next_state;
         count   <= next_count;
         filt    <= next_filt;
         prev_in <= i_in;
      end
   end
endmodule

/* File: rtl/ictd_top.sv */
// Purpose: input capture timer with per channel noise cancelers
// Assumes: one 50 MHz peripheral clock; pins are asynchronous
// Notes: control bits are plain ports; no register bus
// How it works
// - common mode bit picks one of two filters
// - premature mode passes first change, starts counter
// - premature mode ignores changes while counting
// - premature mode takes input level on match
// - minimum mode starts counting on change, stops
// - minimum mode outputs change only on match
// - minimum mode aborts and discards on early change
// - counter counts only while master enable set
// - wrap sets flag and keeps counting
// - wrap interrupt when flag and enable set
// - clearing enable freezes counter, resume later
// - software write overrides increment, counting continues
// - counter write completes in two cycles
// - prescaler runs free of master enable
// - capture edge sets flag, copies counter
// - edge select rising, falling or both
// - enabled capture raises interrupt, also DMA request
// - capture during counter write takes old value
// - DMA acceptance clears capture flag
// - capture edges taken from filtered signal
// - noise counters ignore the master enable
// - noise counter clears and stops after match
// - disabling canceler mid-count does not stop it
`timescale 1ns/1ps
`include "ictd_map.svh"
module ictd_top
   import ictd_pkg::*;
#(
   parameter int CH    = `ICTD_CHANNELS,
   parameter int CNT_W = `ICTD_CNT_W,
   parameter int NC_W  = `ICTD_NC_W,
   parameter int PRE_W = `ICTD_PRE_W
) (
   input  wire logic                 i_clk,
   input  wire logic                 i_rstn,
   input  wire logic [CH-1:0]        i_capture_input_pin,
   input  wire logic                 i_capture_timer_enable,
   input  wire logic                 i_noise_mode_select,
   input  wire logic [CH-1:0]        i_deglitch_enable,
   input  wire logic [CH*NC_W-1:0]   i_deglitch_limit,
   input  wire logic [CH*2-1:0]      i_channel_edge_config,
   input  wire logic [PRE_W-1:0]     i_count_divide,
   input  wire logic [PRE_W-1:0]     i_deglitch_divide,
   input  wire logic                 i_count_write,
   input  wire logic [CNT_W-1:0]     i_count_wdata,
   input  wire logic [CH-1:0]        i_capture_write,
   input  wire logic [CNT_W-1:0]     i_capture_wdata,
   input  wire logic                 i_wrap_irq_enable,
   input  wire logic                 i_wrap_flag_clear,
   input  wire logic [CH-1:0]        i_capture_irq_enable,
   input  wire logic [CH-1:0]        i_capture_flag_clear,
   input  wire logic [CH-1:0]        i_dma_ack,
   output logic [CNT_W-1:0]          o_free_running_count,
   output logic                      o_count_write_busy,
   output logic                      o_wrap_flag,
   output logic                      o_wrap_irq,
   output logic [CH-1:0]             o_capture_flag,
   output logic [CH-1:0]             o_capture_irq,
   output logic [CH*CNT_W-1:0]       o_capture_value_set,
   output logic [CH*NC_W-1:0]        o_deglitch_counter,
   output logic [CH-1:0]             o_filtered
);
   initial begin
      if (CH < 1 || CNT_W < 2 || NC_W < 1 || PRE_W < 1) $error("ictd_top: bad parameter");
   end

   // two-stage synchronisers
   logic [CH-1:0]      sync_a;
   logic [CH-1:0]      sync_b;
   logic [CH-1:0]      filt_q;
   logic [CH-1:0]      filt_d;
   // prescalers
   logic [PRE_W-1:0]   pre_cnt;
   logic [PRE_W-1:0]   next_pre_cnt;
   logic [PRE_W-1:0]   nc_pre_cnt;
   logic [PRE_W-1:0]   next_nc_pre_cnt;
   logic               count_tick;
   logic               nc_tick;
   // counter and write path
   logic [CNT_W-1:0]   count;
   logic [CNT_W-1:0]   next_count;
   logic               wr_pend;
   logic               next_wr_pend;
   logic [CNT_W-1:0]   wr_data;
   logic [CNT_W-1:0]   next_wr_data;
   logic               wrap;
   logic               next_wrap;
   // capture
   logic [CH-1:0]      cap_flag;
   logic [CH-1:0]      next_cap_flag;
   logic [CH*CNT_W-1:0] cap_val;
   logic [CH*CNT_W-1:0] next_cap_val;
   logic [CH-1:0]      edge_hit;
   logic [CH-1:0]      next_filtered;

   assign count_tick = (pre_cnt == i_count_divide);
   assign nc_tick    = (nc_pre_cnt == i_deglitch_divide);

   // prescalers free-run, never gated by the master enable
   always_comb begin
      next_pre_cnt    = count_tick ? '0 : pre_cnt + 1'b1;
      next_nc_pre_cnt = nc_tick ? '0 : nc_pre_cnt + 1'b1;
   end

   for (genvar c = 0; c < CH; c++) begin : g_ch
      ictd_deglitch #(.NC_W(NC_W)) u_nc (
         .i_clk    (i_clk),
         .i_rstn   (i_rstn),
         .i_in     (sync_b[c]),
         .i_enable (i_deglitch_enable[c]),
         .i_mode   (i_noise_mode_select),
         .i_tick   (nc_tick),
         .i_limit  (i_deglitch_limit[c*NC_W +: NC_W]),
         .o_out    (filt_d[c]),
         .o_count  (o_deglitch_counter[c*NC_W +: NC_W])
      );
   end

   // edge detect on filtered signal
   always_comb begin
      next_filtered = filt_d;
      for (int c = 0; c < CH; c++) begin
         unique case (i_channel_edge_config[c*2 +: 2])
            `ICTD_EDGE_RISE: edge_hit[c] = filt_d[c] & ~filt_q[c];
            `ICTD_EDGE_FALL: edge_hit[c] = ~filt_d[c] & filt_q[c];
            `ICTD_EDGE_BOTH: edge_hit[c] = filt_d[c] ^ filt_q[c];
            `ICTD_EDGE_OFF:  edge_hit[c] = 1'b0;
         endcase
      end
   end

   // counter: a write is taken in cycle one and lands in cycle two
   always_comb begin
      next_count   = count;
      next_wr_pend = 1'b0;
      next_wr_data = wr_data;
      next_wrap    = wrap;
      if (i_count_write && !wr_pend) begin
         next_wr_pend = 1'b1;
         next_wr_data = i_count_wdata;
      end
      if (wr_pend) begin
         next_count = wr_data;
      end else if (i_capture_timer_enable && count_tick) begin
         next_count = count + 1'b1;
         if (count == `ICTD_CNT_MAX) begin
            next_wrap = 1'b1;
         end
      end
      if (i_wrap_flag_clear && !(next_wrap && !wrap)) begin
         next_wrap = 1'b0;
      end
   end

   // capture flags and values; set wins over clear
   always_comb begin
      next_cap_flag = cap_flag;
      next_cap_val  = cap_val;
      for (int c = 0; c < CH; c++) begin
         if (i_capture_write[c]) begin
            next_cap_val[c*CNT_W +: CNT_W] = i_capture_wdata;
         end
         if (i_capture_flag_clear[c] || (i_dma_ack[c] && o_capture_irq[c])) begin
            next_cap_flag[c] = 1'b0;
         end
         if (edge_hit[c]) begin
            next_cap_flag[c] = 1'b1;
            next_cap_val[c*CNT_W +: CNT_W] = count;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sync_a     <= '0;
         sync_b     <= '0;
         filt_q     <= '0;
         pre_cnt    <= '0;
         nc_pre_cnt <= '0;
         count      <= `ICTD_CNT_RST;
         wr_pend    <= 1'b0;
         wr_data    <= `ICTD_CNT_RST;
         wrap       <= 1'b0;
         cap_flag   <= '0;
         cap_val    <= '0;
      end else begin
         sync_a     <= i_capture_input_pin;
         sync_b     <= sync_a;
         filt_q     <= next_filtered;
         pre_cnt    <= next_pre_cnt;
         nc_pre_cnt <= next_nc_pre_cnt;
         count      <= next_count;
         wr_pend    <= next_wr_pend;
         wr_data    <= next_wr_data;
         wrap       <= next_wrap;
         cap_flag   <= next_cap_flag;
         cap_val    <= next_cap_val;
      end
   end

   assign o_free_running_count = count;
   assign o_count_write_busy   = wr_pend;
   assign o_wrap_flag          = wrap;
   assign o_wrap_irq           = wrap & i_wrap_irq_enable;
   assign o_capture_flag       = cap_flag;
   assign o_capture_irq        = cap_flag & i_capture_irq_enable;
   assign o_capture_value_set  = cap_val;
   assign o_filtered           = filt_q;
endmodule

/* File: sim/ictd_asserts.sv */
// Purpose: port checker for ictd_top
// Assumes: one clock, async active-low reset
// Notes: DMA-clear and noise-counter rules watched on channel 0; capture irq rule on all channels
`timescale 1ns/1ps
module ictd_asserts #(
   parameter int CH    = 6,
   parameter int CNT_W = 32,
   parameter int NC_W  = 8
) (
   input wire logic               i_clk,
   input wire logic               i_rstn,
   input wire logic               i_capture_timer_enable,
   input wire logic               i_count_write,
   input wire logic [CNT_W-1:0]   i_count_wdata,
   input wire logic               i_wrap_irq_enable,
   input wire logic [CH-1:0]      i_capture_irq_enable,
   input wire logic [CH-1:0]      i_dma_ack,
   input wire logic [CH*NC_W-1:0] i_deglitch_limit,
   input wire logic [CNT_W-1:0]   o_free_running_count,
   input wire logic               o_count_write_busy,
   input wire logic               o_wrap_flag,
   input wire logic               o_wrap_irq,
   input wire logic [CH-1:0]      o_capture_flag,
   input wire logic [CH-1:0]      o_capture_irq,
   input wire logic [CH-1:0]      o_filtered,
   input wire logic [CH*NC_W-1:0] o_deglitch_counter
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   a_count_frozen: assert property (!i_capture_timer_enable && !o_count_write_busy
      |=> $stable(o_free_running_count)) else $error("counter moved while disabled");
   a_count_step: assert property (!o_count_write_busy
      |=> o_free_running_count - $past(o_free_running_count) <= 1) else $error("counter jumped");
   a_write_lands: assert property (i_count_write && !o_count_write_busy
      |=> o_count_write_busy ##1 o_free_running_count == $past(i_count_wdata, 2)) else $error("write lost");
   a_wrap_sets: assert property (i_capture_timer_enable && !o_count_write_busy && &o_free_running_count
      ##1 o_free_running_count == '0 |-> ##[0:1] o_wrap_flag) else $error("wrap flag missing");
   a_wrap_irq: assert property (o_wrap_irq == (o_wrap_flag && i_wrap_irq_enable))
      else $error("wrap irq wrong");
   a_capture_irq: assert property (o_capture_irq == (o_capture_flag & i_capture_irq_enable))
      else $error("capture irq wrong");
   a_dma_clear: assert property (i_dma_ack[0] && o_capture_irq[0]
      |=> !o_capture_flag[0] || $changed(o_filtered[0])) else $error("dma did not clear flag");
   a_nc_clear: assert property (o_deglitch_counter[NC_W-1:0] != '0
      && o_deglitch_counter[NC_W-1:0] == i_deglitch_limit[NC_W-1:0]
      |=> o_deglitch_counter[NC_W-1:0] == '0) else $error("noise counter not cleared");
   c_wrap: cover property ($rose(o_wrap_flag));
   c_capture: cover property ($rose(o_capture_flag[0]));
   c_dma: cover property (i_dma_ack[0] && o_capture_irq[0]);
endmodule
bind ictd_top ictd_asserts #(.CH(CH), .CNT_W(CNT_W), .NC_W(NC_W)) ictd_asserts_i (
   .i_clk(i_clk), .i_rstn(i_rstn), .i_capture_timer_enable(i_capture_timer_enable),
   .i_count_write(i_count_write), .i_count_wdata(i_count_wdata), .i_wrap_irq_enable(i_wrap_irq_enable),
   .i_capture_irq_enable(i_capture_irq_enable), .i_dma_ack(i_dma_ack), .i_deglitch_limit(i_deglitch_limit),
   .o_free_running_count(o_free_running_count), .o_count_write_busy(o_count_write_busy),
   .o_wrap_flag(o_wrap_flag), .o_wrap_irq(o_wrap_irq), .o_capture_flag(o_capture_flag),
   .o_capture_irq(o_capture_irq), .o_filtered(o_filtered), .o_deglitch_counter(o_deglitch_counter));

/* File: sim/ictd_pins.sv */
// Purpose: external pulse sources on the capture pins
// Assumes: bench calls drive from its main sequence
// Notes: pins change just after an edge and hold
`timescale 1ns/1ps
module ictd_pins (
   input  wire logic i_clk,
   output logic [5:0] o_pin
);
   initial o_pin = 6'h00;
   task automatic drive(input int c, input logic v, input int n);
      @(posedge i_clk);
      o_pin[c] <= v;
      repeat (n) @(posedge i_clk);
   endtask
endmodule

/* File: sim/ictd_top_tb.sv */
// Purpose: self-checking bench for ictd_top
// Assumes: 50 MHz clock, reset low for 8 cycles
// Notes: counter frozen during captures so the captured value is known
`timescale 1ns/1ps
module ictd_top_tb;
   logic          i_clk = 1'b0;
   logic          i_rstn = 1'b0;
   logic          en = 1'b0, mode = 1'b0, cwr = 1'b0, wie = 1'b0, wclr = 1'b0;
   logic [5:0]    dge = 6'h00, cie = 6'h3f, dack = 6'h00, pin, cflag, cirq, fil, prv;
   logic [47:0]   lim = 48'h0, ncnt;
   logic [11:0]   cfg = 12'h000;
   logic [31:0]   wdata = 32'h0, cnt, v, got;
   logic [191:0]  cval;
   logic          busy, wflag, wirq;
   logic [31:0]   expq[$];
   int            fail_count = 0, compares = 0, cyc = 0;
   ictd_pins ictd_pins_i (.i_clk(i_clk), .o_pin(pin));
   ictd_top ictd_top_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_capture_input_pin(pin),
      .i_capture_timer_enable(en), .i_noise_mode_select(mode), .i_deglitch_enable(dge),
      .i_deglitch_limit(lim), .i_channel_edge_config(cfg), .i_count_divide(8'h00),
      .i_deglitch_divide(8'h00), .i_count_write(cwr), .i_count_wdata(wdata), .i_capture_write(6'h00),
      .i_capture_wdata(32'h0), .i_wrap_irq_enable(wie), .i_wrap_flag_clear(wclr),
      .i_capture_irq_enable(cie), .i_capture_flag_clear(6'h00), .i_dma_ack(dack),
      .o_free_running_count(cnt), .o_count_write_busy(busy), .o_wrap_flag(wflag), .o_wrap_irq(wirq),
      .o_capture_flag(cflag), .o_capture_irq(cirq), .o_capture_value_set(cval),
      .o_deglitch_counter(ncnt), .o_filtered(fil));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(input logic [31:0] d);
      @(posedge i_clk);
      cwr <= 1'b1;
      wdata <= d;
      @(posedge i_clk);
      cwr <= 1'b0;
      #1 chk(busy, 1'b1);
      repeat (2) @(posedge i_clk);
   endtask
   initial forever #10 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc++;
      if (cyc > 20000) begin
         fail_count++;
         end_sim();
      end
   end
   // each selected filtered edge must match the oldest expected capture
   always @(posedge i_clk) begin
      #1;
      for (int c = 0; c < 6; c++)
         if (i_rstn && fil[c] !== prv[c] && cfg[2*c + (fil[c] ? 0 : 1)]) begin
            got = (expq.size() > 0) ? expq.pop_front() : ~cval[32*c +: 32];
            chk(cval[32*c +: 32], got);
            chk(cflag[c], 1'b1);
         end
      prv = fil;
   end
   initial begin
      v = $urandom(32'h22cadfb2);
      repeat (8) @(posedge i_clk);
      i_rstn <= 1'b1;
      wr(32'hffff_fff0);
      repeat (3) @(posedge i_clk);
      #1 chk(cnt, 32'hffff_fff0);
      wie <= 1'b1;
      en <= 1'b1;
      for (int i = 0; i < 40 && wflag !== 1'b1; i++) begin
         @(posedge i_clk);
         #1;
      end
      #1 chk(wflag, 1'b1);
      chk(wirq, 1'b1);
      chk(cnt & 32'hffff_ff00, 32'h0);
      en <= 1'b0;
      wclr <= 1'b1;
      @(posedge i_clk);
      wclr <= 1'b0;
      #1 chk(wflag, 1'b0);
      $display("wrap test done");
      v = $urandom;
      wr(v);
      for (int c = 0; c < 4; c++) begin
         cfg[2*c +: 2] <= c[1:0];
         if (c[0]) expq.push_back(v);
         if (c[1]) expq.push_back(v);
         ictd_pins_i.drive(c, 1'b1, 6);
         ictd_pins_i.drive(c, 1'b0, 6);
         dack[c] <= 1'b1;
         #1 chk(cflag[c], c != 0);
         @(posedge i_clk);
         dack[c] <= 1'b0;
         @(posedge i_clk);
         #1 chk(cflag[c], 1'b0);
      end
      $display("edge select test done");
      cfg[11:8] <= 4'hf;
      dge[5:4] <= 2'h3;
      lim[47:32] <= {8'h06 + 8'($urandom % 3), 8'h06 + 8'($urandom % 3)};
      repeat (2) expq.push_back(v);
      ictd_pins_i.drive(4, 1'b1, 3);
      dge[4] <= 1'b0;
      ictd_pins_i.drive(4, 1'b0, 1);
      ictd_pins_i.drive(4, 1'b1, 12);
      ictd_pins_i.drive(4, 1'b0, 12);
      $display("premature mode test done");
      mode <= 1'b1;
      repeat (2) expq.push_back(v);
      ictd_pins_i.drive(5, 1'b1, 1);
      ictd_pins_i.drive(5, 1'b0, 12);
      ictd_pins_i.drive(5, 1'b1, 12);
      ictd_pins_i.drive(5, 1'b0, 12);
      repeat (4) @(posedge i_clk);
      #1 chk(expq.size(), 0);
      chk(ncnt[47:32], 16'h0);
      $display("minimum level test done");
      end_sim();
   end
endmodule
